//--- rtl/flash_front_pkg.sv
// Constants and types shared by the serial flash command front end
package flash_front_pkg;

  // Instruction opcodes
  localparam logic [7:0] OP_SET_WRITE_PERMISSION_CMD     = 8'h06;
  localparam logic [7:0] OP_VOLWREN  = 8'h50;
  localparam logic [7:0] OP_CLEAR_WRITE_PERMISSION_CMD     = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD     = 8'h05;
  localparam logic [7:0] OP_WRSR     = 8'h01;
  localparam logic [7:0] OP_PROG     = 8'h02;
  localparam logic [7:0] OP_SE4K     = 8'h20;
  localparam logic [7:0] OP_BE32K    = 8'h52;
  localparam logic [7:0] OP_BE64K    = 8'hD8;
  localparam logic [7:0] OP_CE_A     = 8'hC7;
  localparam logic [7:0] OP_CE_B     = 8'h60;
  localparam logic [7:0] OP_READ     = 8'h03;
  localparam logic [7:0] OP_FREAD    = 8'h0B;
  localparam logic [7:0] OP_DREAD    = 8'h3B;
  localparam logic [7:0] OP_DIOREAD  = 8'hBB;
  localparam logic [7:0] OP_DEVID    = 8'hAB;
  localparam logic [7:0] OP_RSTEN    = 8'h66;
  localparam logic [7:0] OP_RST      = 8'h99;
  localparam logic [7:0] OP_SECPROG  = 8'h42;
  localparam logic [7:0] OP_SECERASE = 8'h44;

  // Frame lengths in whole bytes
  localparam logic [9:0] LEN_OPCODE  = 10'h001;
  localparam logic [9:0] LEN_WRSR    = 10'h002;
  localparam logic [9:0] LEN_ADDR    = 10'h004;
  localparam logic [9:0] LINK_BYTE_MAX = 10'h3FF;
  localparam logic [9:0] PAGE_BYTES  = 10'h100;

  // First output byte of each read type
  localparam logic [9:0] START_STATUS_READ_CMD  = 10'h001;
  localparam logic [9:0] START_READ  = 10'h004;
  localparam logic [9:0] START_FAST  = 10'h005;
  localparam logic [9:0] START_DIO   = 10'h003;
  localparam logic [9:0] START_NONE  = 10'h000;

  // Dual address window ends at clock 20
  localparam logic [9:0] DIO_ADDR_LAST_BYTE = 10'h002;
  localparam logic [2:0] DIO_ADDR_END_BIT   = 3'h4;

  // Security sector address fields
  localparam logic [7:0] SEC_HI        = 8'h00;
  localparam logic [7:0] SEC_MID_FIRST = 8'h10;
  localparam logic [7:0] SEC_MID_LAST  = 8'h13;

  // Status byte layout
  localparam int         ST_BUSY        = 0;
  localparam int         ST_WEL         = 1;
  localparam logic [7:0] STATUS_WR_MASK = 8'hBC;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  typedef enum logic [0:0] {
    CORE_IDLE = 1'b0,
    CORE_BUSY = 1'b1
  } core_state_t;

  typedef struct packed {
    core_state_t state;
    logic        csPrev;
    logic        write_enable_latch;
    logic        volArm;
    logic        rstArm;
    logic        nvPend;
    logic [7:0]  nvProt;
    logic [7:0]  vProt;
    logic [7:0]  pendProt;
    logic        opStart;
    logic [7:0]  opCode;
    logic [23:0] opAddr;
    logic [8:0]  opLen;
    logic [7:0]  pageData;
  } core_t;

endpackage

//--- rtl/pin_sync3.sv
// Three stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output var  logic pinStable
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic stable_reg;

  // First stage feeds only the second; change accepted when stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
      stable_reg <= RESET_VAL;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      if (stage2_reg == stage3_reg) begin
        stable_reg <= stage3_reg;
      end
    end
  end

  assign pinStable = stable_reg;

endmodule
`default_nettype wire

//--- rtl/flash_cmd_front.sv
// Serial flash command front end: link decoder and write control core
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_front
  import flash_front_pkg::*;
#(
  parameter logic [7:0] ID_BYTE = 8'h5A  // Arbitrary identifier value
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sclk,
  input  wire logic        csN,
  input  wire logic        ioLane0In,
  input  wire logic        ioLane1In,
  output var  logic        ioLane0Out,
  output var  logic        ioLane0OeN,
  output var  logic        ioLane1Out,
  output var  logic        ioLane1OeN,
  output var  logic [23:0] rdAddr,
  input  wire logic [7:0]  rdData,
  output var  logic        opStart,
  output var  logic [7:0]  opCode,
  output var  logic [23:0] opAddr,
  output var  logic [8:0]  opLen,
  input  wire logic        opDone,
  input  wire logic [7:0]  pageRdIdx,
  output var  logic [7:0]  pageRdData,
  output var  logic [7:0]  protBits,
  output var  logic        busyFlag,
  output var  logic        writeEnableLatch
);

  // Output start byte per opcode, none for everything else
  function automatic logic [9:0] dataStartByte(input logic [7:0] op);
    case (op)
      OP_STATUS_READ_CMD:              dataStartByte = START_STATUS_READ_CMD;
      OP_READ, OP_DEVID:    dataStartByte = START_READ;
      OP_FREAD, OP_DREAD:   dataStartByte = START_FAST;
      OP_DIOREAD:           dataStartByte = START_DIO;
      default:              dataStartByte = START_NONE;
    endcase
  endfunction

  function automatic logic isDualOut(input logic [7:0] op);
    isDualOut = (op == OP_DREAD) || (op == OP_DIOREAD);
  endfunction

  function automatic logic isProgram(input logic [7:0] op);
    isProgram = (op == OP_PROG) || (op == OP_SECPROG);
  endfunction

  function automatic logic usesSingleAddr(input logic [7:0] op);
    case (op)
      OP_PROG, OP_SECPROG, OP_SE4K, OP_BE32K, OP_BE64K, OP_SECERASE,
      OP_READ, OP_FREAD, OP_DREAD: usesSingleAddr = 1'b1;
      default:                     usesSingleAddr = 1'b0;
    endcase
  endfunction

  // ---------------- Link domain (serial clock) ----------------
  logic [2:0]  bitPos_reg;
  logic [9:0]  byteCnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  opcode_reg;
  logic [23:0] addr_reg;
  logic [7:0]  wrsrData_reg;
  logic [7:0]  statMeta_reg;
  logic [7:0]  statSync_reg;
  logic [2:0]  endBit_reg;
  logic [9:0]  endByte_reg;
  logic [7:0]  statusByte;
  logic [7:0]  pageBuf_reg [256];
  logic        drive0_reg;
  logic        drive1_reg;
  logic        out0_reg;
  logic        out1_reg;
  logic [7:0]  inByte;
  logic        busyLink;
  logic        bufWe;
  logic [7:0]  bufIdx;
  logic [9:0]  startByte;
  logic [12:0] relBits;
  logic        outActive;
  logic [7:0]  outByte;
  logic [1:0]  pairIdx;

  assign inByte   = {shift_reg[6:0], ioLane0In};
  assign busyLink = statSync_reg[ST_BUSY];

  // select rising clears the frame counters
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitPos_reg  <= 3'h0;
      byteCnt_reg <= 10'h000;
    end else begin
      bitPos_reg <= bitPos_reg + 3'h1;
      if (bitPos_reg == 3'h7 && byteCnt_reg != LINK_BYTE_MAX) begin
        byteCnt_reg <= byteCnt_reg + 10'h001;
      end
    end
  end

  // capture on rising edge; descriptor held after frame for the core
  always_ff @(posedge sclk) begin
    shift_reg <= inByte;
    statMeta_reg <= statusByte;
    statSync_reg <= statMeta_reg;
    // Frame length survives the select rise that clears the counters
    endBit_reg  <= bitPos_reg + 3'h1;
    endByte_reg <= (bitPos_reg == 3'h7 && byteCnt_reg != LINK_BYTE_MAX) ?
                   byteCnt_reg + 10'h001 : byteCnt_reg;
    if (byteCnt_reg == 10'h000 && bitPos_reg == 3'h7) begin
      opcode_reg <= inByte;
    end
    if (byteCnt_reg == LEN_OPCODE && bitPos_reg == 3'h7) begin
      wrsrData_reg <= inByte;
    end
    if (usesSingleAddr(opcode_reg) && byteCnt_reg != 10'h000 &&
        byteCnt_reg < LEN_ADDR) begin
      addr_reg <= {addr_reg[22:0], ioLane0In};
    end
    // dual address: lane one odd bit, lane zero even bit
    if (opcode_reg == OP_DIOREAD &&
        (byteCnt_reg == LEN_OPCODE ||
         (byteCnt_reg == DIO_ADDR_LAST_BYTE &&
          bitPos_reg < DIO_ADDR_END_BIT))) begin
      addr_reg <= {addr_reg[21:0], ioLane1In, ioLane0In};
    end
    if (bufWe) begin
      pageBuf_reg[bufIdx] <= inByte;
    end
  end

  // page index wraps naturally at 256
  assign bufIdx = addr_reg[7:0] + byteCnt_reg[7:0] - LEN_ADDR[7:0];
  // data bytes follow the three address bytes
  assign bufWe  = !csN && isProgram(opcode_reg) && !busyLink &&
                  byteCnt_reg >= LEN_ADDR && bitPos_reg == 3'h7;

  // Output position relative to the first output clock
  assign startByte = dataStartByte(opcode_reg);
  assign relBits   = {byteCnt_reg, bitPos_reg} - {startByte, 3'h0};
  assign pairIdx   = relBits[1:0];
  // status read stays live while busy; other reads drop out
  assign outActive = startByte != START_NONE && byteCnt_reg >= startByte &&
                     (opcode_reg == OP_STATUS_READ_CMD || !busyLink);
  assign rdAddr    = isDualOut(opcode_reg) ?
                     addr_reg + {13'h0000, relBits[12:2]} :
                     addr_reg + {14'h0000, relBits[12:3]};

  // status and identifier bytes repeat for every byte slot
  always_comb begin
    case (opcode_reg)
      OP_STATUS_READ_CMD:  outByte = statSync_reg;
      OP_DEVID: outByte = ID_BYTE;
      default:  outByte = rdData;
    endcase
  end

  // output changes on falling edges; released with select high
  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      drive0_reg <= 1'b0;
      drive1_reg <= 1'b0;
      out0_reg   <= 1'b0;
      out1_reg   <= 1'b0;
    end else begin
      // unknown opcodes never enable the drivers
      drive1_reg <= outActive;
      // lane zero only joins for dual reads
      drive0_reg <= outActive && isDualOut(opcode_reg);
      if (isDualOut(opcode_reg)) begin
        // odd bits on lane one, even bits on lane zero
        out1_reg <= outByte[3'h7 - {pairIdx, 1'b0}];
        out0_reg <= outByte[3'h6 - {pairIdx, 1'b0}];
      end else begin
        out1_reg <= outByte[3'h7 - relBits[2:0]];
        out0_reg <= 1'b0;
      end
    end
  end

  assign ioLane0Out = out0_reg;
  assign ioLane1Out = out1_reg;
  assign ioLane0OeN = !drive0_reg;
  assign ioLane1OeN = !drive1_reg;

  // ---------------- Core domain (system clock) ----------------
  core_t st_reg;
  core_t st_next;
  logic  csStable;
  logic  endEdge;
  logic  aligned;
  logic  secOk;
  logic  busy;
  logic  [9:0] dataBytes;

  pin_sync3 #(
    .RESET_VAL (1'b1)
  ) csSync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pinIn     (csN),
    .pinStable (csStable)
  );

  // Link descriptor is quiet once select has settled high
  assign endEdge   = csStable && !st_reg.csPrev;
  assign aligned   = endBit_reg == 3'h0;
  assign busy      = st_reg.state == CORE_BUSY;
  assign dataBytes = endByte_reg - LEN_ADDR;
  assign secOk     = addr_reg[23:16] == SEC_HI &&
                     addr_reg[15:8] >= SEC_MID_FIRST &&
                     addr_reg[15:8] <= SEC_MID_LAST;
  // busy in bit 0, latch in bit 1
  assign statusByte = (st_reg.vProt & STATUS_WR_MASK) |
                      {6'h00, st_reg.write_enable_latch, busy};

  // Instruction execution at frame end
  always_comb begin
    st_next          = st_reg;
    st_next.opStart  = 1'b0;
    st_next.csPrev   = csStable;
    st_next.pageData = pageBuf_reg[pageRdIdx];
    // slow cycle completion drops the latch
    if (busy && opDone) begin
      st_next.state = CORE_IDLE;
      st_next.write_enable_latch   = 1'b0;
      if (st_reg.nvPend) begin
        st_next.nvProt = st_reg.pendProt;
        st_next.vProt  = st_reg.pendProt;
        st_next.nvPend = 1'b0;
      end
    end
    // frames ending while busy are dropped
    if (endEdge && !busy) begin
      st_next.rstArm = 1'b0;
      case (opcode_reg)
        // set latch on a one-byte frame
        OP_SET_WRITE_PERMISSION_CMD: if (endByte_reg == LEN_OPCODE && aligned) begin
          st_next.write_enable_latch = 1'b1;
        end
        // clear latch on a one-byte frame
        OP_CLEAR_WRITE_PERMISSION_CMD: if (endByte_reg == LEN_OPCODE && aligned) begin
          st_next.write_enable_latch = 1'b0;
        end
        // arm the volatile permit, latch untouched
        OP_VOLWREN: if (endByte_reg == LEN_OPCODE && aligned) begin
          st_next.volArm = 1'b1;
        end
        OP_RSTEN: if (endByte_reg == LEN_OPCODE && aligned) begin
          st_next.rstArm = 1'b1;
        end
        // reset drops latch and restores non-volatile protection
        OP_RST: if (endByte_reg == LEN_OPCODE && aligned &&
                    st_reg.rstArm) begin
          st_next.write_enable_latch    = 1'b0;
          st_next.volArm = 1'b0;
          st_next.vProt  = st_reg.nvProt;
        end
        OP_WRSR: if (endByte_reg == LEN_WRSR && aligned) begin
          if (st_reg.volArm) begin
            // volatile copy updated with no busy cycle
            st_next.vProt  = (st_reg.vProt & ~STATUS_WR_MASK) |
                             (wrsrData_reg & STATUS_WR_MASK);
            st_next.volArm = 1'b0;
          end else if (st_reg.write_enable_latch) begin
            st_next.state    = CORE_BUSY;
            st_next.opStart  = 1'b1;
            st_next.opCode   = opcode_reg;
            st_next.nvPend   = 1'b1;
            st_next.pendProt = wrsrData_reg & STATUS_WR_MASK;
          end
        end
        // program needs latch, data and whole bytes
        OP_PROG, OP_SECPROG:
          if (st_reg.write_enable_latch && aligned && endByte_reg > LEN_ADDR &&
              (opcode_reg == OP_PROG || secOk)) begin
            st_next.state   = CORE_BUSY;
            st_next.opStart = 1'b1;
            st_next.opCode  = opcode_reg;
            st_next.opAddr  = addr_reg;
            st_next.opLen   = dataBytes > PAGE_BYTES ?
                              PAGE_BYTES[8:0] : dataBytes[8:0];
          end
        OP_SE4K, OP_BE32K, OP_BE64K, OP_SECERASE:
          if (st_reg.write_enable_latch && aligned && endByte_reg == LEN_ADDR &&
              (opcode_reg != OP_SECERASE || secOk)) begin
            st_next.state   = CORE_BUSY;
            st_next.opStart = 1'b1;
            st_next.opCode  = opcode_reg;
            st_next.opAddr  = addr_reg;
          end
        OP_CE_A, OP_CE_B:
          if (st_reg.write_enable_latch && aligned && endByte_reg == LEN_OPCODE) begin
            st_next.state   = CORE_BUSY;
            st_next.opStart = 1'b1;
            st_next.opCode  = opcode_reg;
          end
        default: st_next.rstArm = 1'b0;
      endcase
    end
  end

  // latch and state cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg        <= '0;
      // Select idles high; avoids a false frame end after reset
      st_reg.csPrev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign opStart          = st_reg.opStart;
  assign opCode           = st_reg.opCode;
  assign opAddr           = st_reg.opAddr;
  assign opLen            = st_reg.opLen;
  assign pageRdData       = st_reg.pageData;
  assign protBits         = st_reg.vProt & STATUS_WR_MASK;
  assign busyFlag         = busy;
  assign writeEnableLatch = st_reg.write_enable_latch;

  // ---------------- Checks ----------------
  a_wel_set: assert property (@(posedge clk) disable iff (!rst_n)
    endEdge && !busy && opcode_reg == OP_SET_WRITE_PERMISSION_CMD &&
    endByte_reg == LEN_OPCODE && aligned |=> writeEnableLatch)
    else $error("latch not set by write enable");

  a_vol_keeps_wel: assert property (@(posedge clk) disable iff (!rst_n)
    endEdge && !busy && opcode_reg == OP_VOLWREN |=>
    $stable(writeEnableLatch))
    else $error("volatile enable changed latch");

  a_wel_clear: assert property (@(posedge clk) disable iff (!rst_n)
    endEdge && !busy && opcode_reg == OP_CLEAR_WRITE_PERMISSION_CMD &&
    endByte_reg == LEN_OPCODE && aligned |=> !writeEnableLatch)
    else $error("latch not cleared by write disable");

  a_need_wel: assert property (@(posedge clk) disable iff (!rst_n)
    endEdge && !writeEnableLatch && opcode_reg != OP_WRSR |=> !opStart)
    else $error("slow cycle started without latch");

  a_vol_nobusy: assert property (@(posedge clk) disable iff (!rst_n)
    endEdge && !busy && st_reg.volArm && opcode_reg == OP_WRSR &&
    endByte_reg == LEN_WRSR && aligned |=> !busyFlag ##1 !busyFlag)
    else $error("volatile status write went busy");

  a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_n)
    busy && !opDone |=> $stable(writeEnableLatch) && $stable(protBits))
    else $error("state changed during slow cycle");

  a_done_clear: assert property (@(posedge clk) disable iff (!rst_n)
    busy && opDone |=> !busyFlag && !writeEnableLatch)
    else $error("completion left busy or latch set");

  a_start_busy: assert property (@(posedge clk) disable iff (!rst_n)
    opStart |-> busyFlag && statusByte[ST_BUSY])
    else $error("busy flag missing at start");

  a_idle_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    csN |-> ioLane0OeN && ioLane1OeN)
    else $error("output driven with select high");

  a_cmd_hiz: assert property (@(posedge sclk) disable iff (csN)
    byteCnt_reg == 10'h000 || startByte == START_NONE |->
    ioLane1OeN && ioLane0OeN)
    else $error("output driven outside a read phase");

  a_page_wrap: assert property (@(posedge sclk) disable iff (csN)
    bufWe ##8 bufWe |-> bufIdx == $past(bufIdx, 8) + 8'h01)
    else $error("page index did not advance with wrap");

endmodule
`default_nettype wire

//--- tb/spi_host_model.sv
// Host controller model driving select, serial clock and both lanes
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output var  logic sclk,
  output var  logic csN,
  output wire logic ioLane0In,
  output wire logic ioLane1In,
  input  wire logic ioLane0Out,
  input  wire logic ioLane0OeN,
  input  wire logic ioLane1Out,
  input  wire logic ioLane1OeN
);
  logic h0;
  logic h1;
  logic sawDrive;

  // Wire level: device wins where it drives, else the host value
  assign ioLane0In = ioLane0OeN ? h0 : ioLane0Out;
  assign ioLane1In = ioLane1OeN ? h1 : ioLane1Out;

  // Clock parked low and select high outside frames
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    h0 = 1'b0;
    h1 = 1'b1;
    sawDrive = 1'b0;
  end

  task automatic start();
    begin
      sawDrive = 1'b0;
      csN = 1'b0;
      #80;
    end
  endtask

  // select rises only after a whole bit; lanes flip so no stale data
  task automatic stop();
    begin
      #80;
      csN = 1'b1;
      h0 = ~h0;
      h1 = ~h1;
      #100;
    end
  endtask

  // bit set while clock low, MSB first, reply sampled before rise
  task automatic shift(input logic [7:0] tx, input int nb,
                       output logic [7:0] rx);
    begin
      rx = 8'h00;
      for (int i = 0; i < nb; i++) begin
        h0 = tx[7 - i];
        h1 = ~h1;
        #80;
        rx = {rx[6:0], ioLane1In};
        if (!ioLane1OeN || !ioLane0OeN) sawDrive = 1'b1;
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
      end
    end
  endtask

  // dual send: lane one odd bit, lane zero even bit, MSB first
  task automatic dual_tx(input logic [7:0] tx);
    begin
      for (int i = 0; i < 4; i++) begin
        h1 = tx[7 - 2 * i];
        h0 = tx[6 - 2 * i];
        #80;
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
      end
    end
  endtask

  // Dual receive: two bits per clock, lane one first
  task automatic dual(output logic [7:0] rx);
    begin
      rx = 8'h00;
      for (int i = 0; i < 4; i++) begin
        h0 = ~h0;
        h1 = ~h1;
        #80;
        rx = {rx[5:0], ioLane1In, ioLane0In};
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the serial flash command front end
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import flash_front_pkg::*;
  logic        clk;
  logic        rst_n;
  wire         sclk;
  wire         csN;
  wire         l0In;
  wire         l1In;
  logic        l0Out;
  logic        l0OeN;
  logic        l1Out;
  logic        l1OeN;
  logic [23:0] rdAddr;
  logic [7:0]  rdData;
  logic        opStart;
  logic [7:0]  opCode;
  logic [23:0] opAddr;
  logic [8:0]  opLen;
  logic        opDone;
  logic [7:0]  pageRdIdx;
  logic [7:0]  pageRdData;
  logic [7:0]  protBits;
  logic        busyFlag;
  logic        writeEnableLatch;
  logic [7:0]  rx;
  logic [7:0]  s0;
  logic [7:0]  s1;
  logic [7:0]  pg [3] = '{8'h80, 8'h81, 8'h02};
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;
  int          nStart = 0;

  // Array model: byte is a fixed function of its address
  assign rdData = rdAddr[7:0] ^ 8'hA5;

  flash_cmd_front dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN),
    .ioLane0In(l0In), .ioLane1In(l1In), .ioLane0Out(l0Out),
    .ioLane0OeN(l0OeN), .ioLane1Out(l1Out), .ioLane1OeN(l1OeN),
    .rdAddr(rdAddr), .rdData(rdData), .opStart(opStart), .opCode(opCode),
    .opAddr(opAddr), .opLen(opLen), .opDone(opDone),
    .pageRdIdx(pageRdIdx), .pageRdData(pageRdData), .protBits(protBits),
    .busyFlag(busyFlag), .writeEnableLatch(writeEnableLatch));

  spi_host_model host (.sclk(sclk), .csN(csN), .ioLane0In(l0In),
    .ioLane1In(l1In), .ioLane0Out(l0Out), .ioLane0OeN(l0OeN),
    .ioLane1Out(l1Out), .ioLane1OeN(l1OeN));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Slow cycle counter and hang guard; the long program frame sets the limit
  always @(posedge clk) begin
    cyc++;
    if (opStart === 1'b1) nStart++;
    if (cyc == 80000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    begin
      compares++;
      if (seen !== exp) begin
        n_fail++;
        $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
    end
  endtask

  task automatic report_and_stop();
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Gap lets the synchronised select rise reach the core
  task automatic close();
    begin
      host.stop();
      repeat (12) @(negedge clk);
    end
  endtask

  task automatic cmd(input logic [7:0] op, input int nb);
    begin
      host.start();
      host.shift(op, nb, rx);
      close();
    end
  endtask

  task automatic addr_frame(input logic [7:0] op, input logic [23:0] a);
    begin
      host.start();
      host.shift(op, 8, rx);
      for (int i = 2; i >= 0; i--) host.shift(a[i*8 +: 8], 8, rx);
    end
  endtask

  task automatic two_byte(input logic [7:0] op, input logic [7:0] v);
    begin
      host.start();
      host.shift(op, 8, rx);
      host.shift(v, 8, s0);
      host.shift(v, 8, s1);
      close();
    end
  endtask

  // Status write frame: opcode and exactly one data byte
  task automatic wrsr(input logic [7:0] v);
    begin
      host.start();
      host.shift(OP_WRSR, 8, rx);
      host.shift(v, 8, rx);
      close();
    end
  endtask

  task automatic pulse_done();
    begin
      @(negedge clk) opDone = 1'b1;
      @(negedge clk) opDone = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    opDone = 1'b0;
    pageRdIdx = 8'h00;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    chk({busyFlag, writeEnableLatch, protBits}, 10'h000);
    cmd(OP_SET_WRITE_PERMISSION_CMD, 8);
    chk(writeEnableLatch, 1'b1);
    chk(host.sawDrive, 1'b0);
    two_byte(OP_STATUS_READ_CMD, 8'h00);
    chk({s0, s1}, 16'h0202);
    chk({l0OeN, l1OeN}, 2'b11);
    cmd(OP_CLEAR_WRITE_PERMISSION_CMD, 8);
    chk(writeEnableLatch, 1'b0);
    cmd(OP_SET_WRITE_PERMISSION_CMD, 7);
    chk(writeEnableLatch, 1'b0);
    addr_frame(OP_PROG, 24'h000010);
    host.shift(8'h11, 8, rx);
    close();
    chk(nStart, 0);
    // Page overrun: bytes 256 and 257 must land on slots 0x10 and 0x11, over bytes 0 and 1
    cmd(OP_SET_WRITE_PERMISSION_CMD, 8);
    addr_frame(OP_PROG, 24'h000010);
    for (int n = 0; n < 258; n++)
      host.shift(8'(n) ^ (n > 255 ? 8'h80 : 8'h00), 8, rx);
    close();
    chk({nStart[7:0], opCode, opAddr, opLen}, {8'h01, OP_PROG, 24'h10, 9'h100});
    two_byte(OP_STATUS_READ_CMD, 8'h00);
    chk(s0, 8'h03);
    cmd(OP_CLEAR_WRITE_PERMISSION_CMD, 8);
    chk(writeEnableLatch, 1'b1);
    for (int k = 0; k < 3; k++) begin
      pageRdIdx = 8'h10 + 8'(k);
      repeat (2) @(negedge clk);
      chk(pageRdData, pg[k]);
    end
    pulse_done();
    chk({busyFlag, writeEnableLatch}, 2'b00);
    // Volatile permit serves one status write only
    cmd(OP_VOLWREN, 8);
    chk(writeEnableLatch, 1'b0);
    wrsr(8'hFF);
    chk({nStart[7:0], protBits, busyFlag}, {8'h01, 8'hBC, 1'b0});
    wrsr(8'h00);
    chk({nStart[7:0], protBits}, {8'h01, 8'hBC});
    cmd(OP_SET_WRITE_PERMISSION_CMD, 8);
    addr_frame(OP_SECERASE, 24'h002000);
    close();
    chk(nStart, 1);
    addr_frame(OP_SECERASE, 24'h001200);
    close();
    chk({opCode, opAddr}, {OP_SECERASE, 24'h001200});
    pulse_done();
    two_byte(8'hFF, 8'h00);
    chk({host.sawDrive, protBits, busyFlag}, {1'b0, 8'hBC, 1'b0});
    addr_frame(OP_READ, 24'h000020);
    host.shift(8'h00, 8, s0);
    close();
    chk(s0, 8'h85);
    addr_frame(OP_DREAD, 24'h000020);
    host.shift(8'h00, 8, rx);
    host.dual(s0);
    host.dual(s1);
    close();
    chk({s0, s1}, 16'h8584);
    host.start();
    host.shift(OP_DIOREAD, 8, rx);
    host.dual_tx(8'h00);
    host.dual_tx(8'h00);
    host.dual_tx(8'h21);
    host.dual_tx(8'h00);
    host.dual(s0);
    close();
    chk(s0, 8'h84);
    report_and_stop();
  end
endmodule
`default_nettype wire
